/* hw/usb_module_control_register.sv */
// Module: USB module control register with Wishbone slave and interrupt logic
`timescale 1ns/1ps
`default_nettype none
// Contract
// RULE1 - Enable bit 3; enabling clears ping-pong pointers
// RULE2 - Enable switches configured pull-ups: soft attach
// RULE3 - Other control bits ignored while disabled
// RULE4 - Enable refused without active clock
// RULE5 - Firmware waits for PLL lock first
// RULE6 - Bit 5 reads live single-ended zero
// RULE7 - Bit 6 forces pointers to even bank
// RULE8 - Pointer reset ignored without ping-pong mode
// RULE9 - SETUP token sets hold bit 4
// RULE10 - Hold bit clearable only, never settable
// RULE11 - Pending transfer events stay visible during hold
// RULE12 - Resume bit 2 drives resume signalling
// RULE13 - Firmware holds resume ten milliseconds
// RULE14 - Suspend bit 1 gates engine clock
// RULE15 - Suspended device stays attached, outputs idle
// RULE16 - Firmware suspends only after bus idle
// RULE17 - Bits 7 and 0 read zero
// RULE18 - Transfer status valid only with complete flag
// RULE19 - Resume drives K, returns to J
module usb_module_control_register
  import usb_ctrl_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      ce,
  // Wishbone classic slave
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [3:0]                wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  output logic                           wb_err_o,
  // Engine and bus side
  input  wire logic                      usb_clk_ok,
  input  wire logic                      bus_se0,
  input  wire logic                      setup_token,
  input  wire logic                      transfer_done,
  input  wire logic [7:0]                transfer_status,
  output usb_ctrl_pkg::engine_ctl_t      engine_ctl,
  output usb_ctrl_pkg::phy_drive_t       phy_drive,
  output logic                           module_enabled,
  output logic                           irq
);
  import usb_ctrl_pkg::*;

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed
  {
    logic [1:0]       rst_sync;     // Reset release chain
    logic             en;           // Module enable
    logic             hold;         // Packet processing hold
    logic             resume;       // Resume signalling
    logic             suspend;      // Suspend request
    logic             ppreset;      // Pointer reset request
    logic             se0;          // Sampled single-ended zero
    logic [1:0]       pp_mode;      // Buffering mode
    logic             pullup_cfg;   // Pull-up configured
    logic [IRQ_W-1:0] stat;         // Sticky events
    logic [IRQ_W-1:0] mask;         // Event mask
    logic [7:0]       xfer_stat;    // Latched transfer status
    logic             ack;          // Bus answer
    logic             err;          // Unmapped answer
    logic [31:0]      rdata;        // Read data
    engine_ctl_t      ectl;         // Engine control
    phy_drive_t       phy;          // Transceiver drive
    logic             enabled;      // Enable mirror
    logic             irq;          // Interrupt
  } state_t;

  state_t cur;
  state_t next_s;
  logic   srst_n;

  // Reset released through two flops, shifted in the state register below
  assign srst_n = cur.rst_sync[1];

  // Byte-lane write merge for lane 0
  function automatic logic [7:0] merge8(input logic [7:0] old_v, input logic [7:0] new_v,
                                        input logic sel0);
    merge8 = sel0 ? new_v : old_v;
  endfunction

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  logic       bus_req;
  logic       wr;
  logic [7:0] wbyte;
  logic [7:0] ctl_rd;
  logic [IRQ_W-1:0] events;

  always_comb
  begin
    next_s  = cur;
    bus_req = wb_cyc_i && wb_stb_i && !cur.ack && !cur.err;
    wr      = bus_req && wb_we_i;
    wbyte   = merge8(8'h00, wb_dat_i[7:0], wb_sel_i[0]);
    // Control readback; bits 7 and 0 tied low
    ctl_rd  = {1'b0, cur.ppreset, cur.se0, cur.hold, cur.en, cur.resume,
               cur.suspend, 1'b0};                                   // RULE17
    next_s.ack   = 1'b0;
    next_s.err   = 1'b0;
    next_s.se0   = bus_se0;                                          // RULE6
    // Bus access, answered one cycle after request
    if (bus_req)
    begin
      next_s.rdata = 32'h0000_0000;
      case (wb_adr_i)
        OFS_CONTROL:  next_s.rdata = {24'h000000, ctl_rd};
        OFS_SETUP:    next_s.rdata = {29'h0, cur.pullup_cfg, cur.pp_mode};
        OFS_IRQ_STAT: next_s.rdata = {21'h0, cur.xfer_stat, cur.stat};   // RULE18
        OFS_IRQ_MASK: next_s.rdata = {29'h0, cur.mask};
        default:      next_s.rdata = 32'h0000_0000;
      endcase
      if (wb_adr_i == OFS_CONTROL || wb_adr_i == OFS_SETUP ||
          wb_adr_i == OFS_IRQ_STAT || wb_adr_i == OFS_IRQ_MASK)
        next_s.ack = 1'b1;
      else
        next_s.err = 1'b1;
    end
    // Control writes
    if (wr && wb_adr_i == OFS_CONTROL && wb_sel_i[0])
    begin
      // Enable only with a live clock
      if (wbyte[BIT_MODULE] && !usb_clk_ok)                          // RULE4
        next_s.en = cur.en;
      else
        next_s.en = wbyte[BIT_MODULE];                               // RULE1
      // Other bits accepted only while enabled
      if (cur.en)                                                    // RULE3
      begin
        next_s.resume  = wbyte[BIT_RESUME];                          // RULE12
        next_s.suspend = wbyte[BIT_SUSPEND];                         // RULE14
        next_s.ppreset = wbyte[BIT_PPRESET];                         // RULE7
        // Hold may only be cleared by software
        if (!wbyte[BIT_HOLD])                                        // RULE10
          next_s.hold = 1'b0;
      end
    end
    if (wr && wb_adr_i == OFS_SETUP && wb_sel_i[0])
    begin
      next_s.pp_mode    = wbyte[1:0];
      next_s.pullup_cfg = wbyte[BIT_PULLUP];
    end
    if (wr && wb_adr_i == OFS_IRQ_MASK && wb_sel_i[0])
      next_s.mask = wbyte[IRQ_W-1:0];
    // Disabled module drops dependent state
    if (!next_s.en)                                                  // RULE3
    begin
      next_s.resume  = 1'b0;
      next_s.suspend = 1'b0;
      next_s.hold    = 1'b0;
      next_s.ppreset = 1'b0;
    end
    // SETUP token sets hold; set wins over a clear
    if (cur.en && setup_token)                                       // RULE9
      next_s.hold = 1'b1;
    // Events: hold does not block transfer reports
    events = {cur.en && bus_se0 && !cur.se0, cur.en && transfer_done,
              cur.en && setup_token};                                // RULE11
    if (cur.en && transfer_done)
      next_s.xfer_stat = transfer_status;
    // Write-one-to-clear, set wins
    next_s.stat = cur.stat;
    if (wr && wb_adr_i == OFS_IRQ_STAT && wb_sel_i[0])
      next_s.stat = cur.stat & ~wbyte[IRQ_W-1:0];
    next_s.stat = next_s.stat | events;
    // Engine and transceiver drive
    next_s.ectl.engine_run    = next_s.en && !next_s.hold && !next_s.suspend;
    next_s.ectl.engine_clk_en = next_s.en && !next_s.suspend;        // RULE14
    // Pointers cleared on enable edge or reset request in ping-pong mode
    next_s.ectl.pingpong_clear = (next_s.en && !cur.en) ||           // RULE1
                                 (next_s.ppreset && cur.pp_mode != PP_NONE); // RULE8
    next_s.phy.pullup_on = next_s.en && cur.pullup_cfg;              // RULE2 RULE15
    // Resume drives K; otherwise idle J
    next_s.phy.tx_enable = next_s.en && next_s.resume;               // RULE19
    next_s.phy.line      = (next_s.en && next_s.resume) ? LINE_K : LINE_J; // RULE15
    next_s.enabled       = next_s.en;
    next_s.irq           = |(next_s.stat & cur.mask);
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur.rst_sync   <= 2'b00;
      cur.en         <= RST_CONTROL[BIT_MODULE];
      cur.hold       <= RST_CONTROL[BIT_HOLD];
      cur.resume     <= RST_CONTROL[BIT_RESUME];
      cur.suspend    <= RST_CONTROL[BIT_SUSPEND];
      cur.ppreset    <= RST_CONTROL[BIT_PPRESET];
      cur.se0        <= 1'b0;
      {cur.pullup_cfg, cur.pp_mode} <= RST_SETUP;
      cur.stat       <= RST_IRQ;
      cur.mask       <= RST_IRQ;
      cur.xfer_stat  <= 8'h00;
      cur.ack        <= 1'b0;
      cur.err        <= 1'b0;
      cur.rdata      <= 32'h0000_0000;
      cur.ectl       <= '0;
      cur.phy        <= '0;
      cur.enabled    <= 1'b0;
      cur.irq        <= 1'b0;
    end
    else
    begin
      // Release chain runs regardless of the clock enable
      cur.rst_sync <= {cur.rst_sync[0], 1'b1};
      if (!srst_n)
      begin
        cur.en      <= 1'b0;
        cur.ack     <= 1'b0;
        cur.err     <= 1'b0;
      end
      else if (ce)
      begin
      cur.en         <= next_s.en;
      cur.hold       <= next_s.hold;
      cur.resume     <= next_s.resume;
      cur.suspend    <= next_s.suspend;
      cur.ppreset    <= next_s.ppreset;
      cur.se0        <= next_s.se0;
      cur.pp_mode    <= next_s.pp_mode;
      cur.pullup_cfg <= next_s.pullup_cfg;
      cur.stat       <= next_s.stat;
      cur.mask       <= next_s.mask;
      cur.xfer_stat  <= next_s.xfer_stat;
      cur.ack        <= next_s.ack;
      cur.err        <= next_s.err;
      cur.rdata      <= next_s.rdata;
      cur.ectl       <= next_s.ectl;
      cur.phy        <= next_s.phy;
      cur.enabled    <= next_s.enabled;
      cur.irq        <= next_s.irq;
      end
    end
  end

  // Outputs straight from flops
  assign wb_dat_o       = cur.rdata;
  assign wb_ack_o       = cur.ack;
  assign wb_err_o       = cur.err;
  assign engine_ctl     = cur.ectl;
  assign phy_drive      = cur.phy;
  assign module_enabled = cur.enabled;
  assign irq            = cur.irq;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!srst_n || !ce);

  chk_enable_needs_clock: assert property ($rose(cur.en) |-> $past(usb_clk_ok)) // RULE4
    else $error("enable set without clock");
  chk_enable_clears_pp: assert property ($rose(cur.en) |-> engine_ctl.pingpong_clear) // RULE1
    else $error("pointers not cleared on enable");
  chk_pullup_follows: assert property (phy_drive.pullup_on |-> cur.en) // RULE2
    else $error("pull-up without enable");
  chk_disabled_ignores: assert property (!cur.en |-> !cur.resume && !cur.suspend && !cur.hold) // RULE3
    else $error("control bit live while disabled");
  chk_ctl_zero_bits: assert property (cur.ack && $past(wb_adr_i) == OFS_CONTROL
                                      |-> wb_dat_o[7] == 1'b0 && wb_dat_o[0] == 1'b0) // RULE17
    else $error("unimplemented bit reads one");
  chk_se0_live: assert property (ce && $past(ce) |-> cur.se0 == $past(bus_se0)) // RULE6
    else $error("se0 flag stale");
  chk_setup_holds: assert property (cur.en && setup_token |=> cur.hold) // RULE9
    else $error("setup did not hold");
  chk_hold_no_sw_set: assert property ($rose(cur.hold) |-> $past(setup_token)) // RULE10
    else $error("hold set by software");
  chk_pp_mode_gate: assert property (engine_ctl.pingpong_clear
                                     |-> $past(cur.pp_mode) != PP_NONE || $rose(cur.en)) // RULE8
    else $error("pointer reset in non ping-pong mode");
  chk_resume_k: assert property (cur.en && cur.resume |-> phy_drive.line == LINE_K) // RULE12 RULE19
    else $error("resume not driving K");
  chk_suspend_gate: assert property (cur.suspend |-> !engine_ctl.engine_clk_en) // RULE14
    else $error("engine clocked in suspend");
  chk_suspend_idle: assert property (cur.suspend && !cur.resume |-> phy_drive.line == LINE_J) // RULE15
    else $error("bus not idle in suspend");
  chk_xfer_event: assert property (cur.en && transfer_done |=> cur.stat[IRQ_TRANSFER]) // RULE11 RULE18
    else $error("transfer event lost");

  cov_enable:  cover property ($rose(cur.en));
  cov_setup:   cover property ($rose(cur.hold));
  cov_resume:  cover property (phy_drive.line == LINE_K);
  cov_irq:     cover property ($rose(irq));
endmodule
`default_nettype wire

/* hw/usb_ctrl_pkg.sv */
// Package: register map, field positions, reset values and types of the USB control block
package usb_ctrl_pkg;
  // ==========================================================================
  // Register word offsets (byte addresses)
  // ==========================================================================
  localparam logic [3:0] OFS_CONTROL   = 4'h0;  // usb_module_control
  localparam logic [3:0] OFS_SETUP     = 4'h4;  // Pull-up enable, buffering mode
  localparam logic [3:0] OFS_IRQ_STAT  = 4'h8;  // Sticky event bits
  localparam logic [3:0] OFS_IRQ_MASK  = 4'hc;  // Interrupt mask
  // ==========================================================================
  // Control register fields
  // ==========================================================================
  localparam int BIT_SUSPEND  = 1;
  localparam int BIT_RESUME   = 2;
  localparam int BIT_MODULE   = 3;
  localparam int BIT_HOLD     = 4;
  localparam int BIT_SE0      = 5;
  localparam int BIT_PPRESET  = 6;
  // Setup register fields
  localparam int BIT_PULLUP   = 2;
  // Interrupt bits
  localparam int IRQ_SETUP    = 0;  // SETUP token caused hold
  localparam int IRQ_TRANSFER = 1;  // Transfer complete
  localparam int IRQ_SE0      = 2;  // Single-ended zero seen
  localparam int IRQ_W        = 3;
  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0]       RST_CONTROL = 8'h00;
  localparam logic [2:0]       RST_SETUP   = 3'h0;
  localparam logic [IRQ_W-1:0] RST_IRQ     = 3'h0;
  // Buffering mode code meaning no ping-pong
  localparam logic [1:0]       PP_NONE     = 2'h0;
  // Bus line states driven by the engine
  typedef enum logic [1:0]
  {
    LINE_J   = 2'b00,
    LINE_K   = 2'b01,
    LINE_SE0 = 2'b10
  } line_state_t;
  // Drive to the transceiver
  typedef struct packed
  {
    logic        pullup_on;   // Soft attach
    logic        tx_enable;   // Transceiver output enable
    line_state_t line;        // Forced line state
  } phy_drive_t;
  // Engine-facing control
  typedef struct packed
  {
    logic engine_run;         // Token processing allowed
    logic engine_clk_en;      // Engine clock gate
    logic pingpong_clear;     // Force pointers to even bank
  } engine_ctl_t;
endpackage

/* tb/usb_host_model.sv */
// Far-side model: bus events that the USB host causes at the block
`timescale 1ns/1ps
`default_nettype none
module usb_host_model
(
  input  wire logic       clk,
  output logic            bus_se0,
  output logic            setup_token,
  output logic            transfer_done,
  output logic [7:0]      transfer_status
);
  // ==========================================================================
  // Event drivers
  // ==========================================================================
  // Quiet bus at start
  initial
  begin
    bus_se0         = 1'b0;
    setup_token     = 1'b0;
    transfer_done   = 1'b0;
    transfer_status = 8'h5a;
  end
  // Live single-ended zero level
  task automatic se0(input logic v);
    @(posedge clk);
    bus_se0 <= v;
  endtask
  // One-cycle SETUP token pulse
  task automatic setup();
    @(posedge clk);
    setup_token <= 1'b1;
    @(posedge clk);
    setup_token <= 1'b0;
  endtask
  // Completion pulse; status is scrambled outside it
  task automatic done(input logic [7:0] s);
    @(posedge clk);
    transfer_done   <= 1'b1;
    transfer_status <= s;
    @(posedge clk);
    transfer_done   <= 1'b0;
    transfer_status <= ~s;
  endtask
endmodule
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the USB module control register block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import usb_ctrl_pkg::*;
  // Expected answer of one bus access
  typedef struct packed {logic rd; logic err; logic [31:0] d;} exp_t;
  logic        clk, rst_n, ce, usb_clk_ok;
  logic        wb_cyc_i, wb_stb_i, wb_we_i;
  logic [3:0]  wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rnd;
  logic        wb_ack_o, wb_err_o, module_enabled, irq;
  logic        bus_se0, setup_token, transfer_done;
  logic [7:0]  transfer_status;
  engine_ctl_t engine_ctl;
  phy_drive_t  phy_drive;
  exp_t        exp_q[$];
  exp_t        e;
  int          n_mismatch, tests_run;
  // ==========================================================================
  // Design and far side
  // ==========================================================================
  usb_module_control_register u_dut (.clk(clk), .rst_n(rst_n), .ce(ce),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o), .usb_clk_ok(usb_clk_ok), .bus_se0(bus_se0),
    .setup_token(setup_token), .transfer_done(transfer_done),
    .transfer_status(transfer_status), .engine_ctl(engine_ctl), .phy_drive(phy_drive),
    .module_enabled(module_enabled), .irq(irq));
  usb_host_model u_host (.clk(clk), .bus_se0(bus_se0), .setup_token(setup_token),
    .transfer_done(transfer_done), .transfer_status(transfer_status));
  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Pseudo-random step
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic summarize();
    if (n_mismatch == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Idle cycles
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Classic Wishbone single cycle; expectation noted for the monitor
  task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d,
                     input logic [31:0] x, input logic err);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    exp_q.push_back({~we, err, x});
    do @(posedge clk); while (!(wb_ack_o === 1'b1 || wb_err_o === 1'b1));
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 32'h0, 1'b0);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0, x, 1'b0);
  endtask
  // ==========================================================================
  // Clock, monitor, watchdog
  // ==========================================================================
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Oldest note against each answer
  always @(posedge clk)
    if ((wb_ack_o === 1'b1 || wb_err_o === 1'b1) && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      check({31'h0, wb_err_o}, {31'h0, e.err});
      if (e.rd) check(wb_dat_o, e.d);
    end
  // Hang guard
  initial
  begin
    w(20000);
    n_mismatch++;
    summarize();
  end
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, usb_clk_ok} = '0;
    {wb_adr_i, wb_dat_i, n_mismatch, tests_run} = '0;
    ce = 1'b1;
    wb_sel_i = 4'hf;
    rnd = 32'h6fcd;
    w(16);
    rst_n <= 1'b1;
    w(4);
    rd(OFS_CONTROL, 32'h0);
    wr(OFS_CONTROL, 32'h8);
    rd(OFS_CONTROL, 32'h0);
    usb_clk_ok <= 1'b1;
    w(20);
    wr(OFS_CONTROL, 32'h46);
    rd(OFS_CONTROL, 32'h0);
    wr(OFS_SETUP, 32'h5);
    wr(OFS_CONTROL, 32'h8);
    w(3);
    check({31'h0, module_enabled}, 32'h1);
    check({31'h0, phy_drive.pullup_on}, 32'h1);
    wr(OFS_CONTROL, 32'h48);
    w(3);
    check({31'h0, engine_ctl.pingpong_clear}, 32'h1);
    rd(OFS_CONTROL, 32'h48);
    wr(OFS_SETUP, 32'h4);
    w(3);
    check({31'h0, engine_ctl.pingpong_clear}, 32'h0);
    wr(OFS_CONTROL, 32'h8);
    wr(OFS_IRQ_MASK, 32'h7);
    u_host.se0(1'b1);
    w(3);
    rd(OFS_CONTROL, 32'h28);
    check({31'h0, irq}, 32'h1);
    u_host.se0(1'b0);
    rd(OFS_IRQ_STAT, 32'h4);
    wr(OFS_IRQ_STAT, 32'h4);
    w(3);
    check({31'h0, irq}, 32'h0);
    u_host.setup();
    w(3);
    rd(OFS_CONTROL, 32'h18);
    check({30'h0, engine_ctl.engine_run, irq}, 32'h1);
    wr(OFS_CONTROL, 32'h8);
    rd(OFS_CONTROL, 32'h8);
    check({31'h0, engine_ctl.engine_run}, 32'h1);
    wr(OFS_CONTROL, 32'h18);
    rd(OFS_CONTROL, 32'h8);
    wr(OFS_IRQ_STAT, 32'h7);
    rnd = lfsr(lfsr(rnd));
    u_host.setup();
    u_host.done(rnd[7:0]);
    w(3);
    rd(OFS_IRQ_STAT, {21'h0, rnd[7:0], 3'h3});
    wr(OFS_IRQ_MASK, 32'h0);
    wr(OFS_IRQ_STAT, 32'h7);
    u_host.setup();
    w(3);
    check({31'h0, irq}, 32'h0);
    wr(OFS_IRQ_MASK, 32'h1);
    w(3);
    check({31'h0, irq}, 32'h1);
    wr(OFS_IRQ_STAT, 32'h1);
    wr(OFS_CONTROL, {rnd[31:8], 8'h0c});
    w(3);
    check({29'h0, phy_drive.tx_enable, phy_drive.line}, {29'h0, 1'b1, LINE_K});
    check({31'h0, irq}, 32'h0);
    w(20);
    wr(OFS_CONTROL, 32'h8);
    w(3);
    check({29'h0, phy_drive.tx_enable, phy_drive.line}, {29'h0, 1'b0, LINE_J});
    wr(OFS_CONTROL, 32'ha);
    w(3);
    check({31'h0, engine_ctl.engine_clk_en}, 32'h0);
    check({phy_drive.pullup_on, phy_drive.line}, {1'b1, LINE_J});
    wr(OFS_CONTROL, 32'h8);
    w(3);
    check({31'h0, engine_ctl.engine_clk_en}, 32'h1);
    bus(1'b0, 4'h2, 32'h0, 32'h0, 1'b1);
    w(4);
    summarize();
  end
endmodule
`default_nettype wire
